// ### core/fes_top.sv
// fault status and charger emulation status registers of the port switch
`timescale 1ns/1ps
`include "fes_consts.svh"

// Operation
// (R1) emulating flag set while active and emulating
// (R2) applied profile reported in four-bit field
// (R3) pair index follows applied stimulus pair
// (R4) legacy profiles never show pair three; the code holds the previous pair, which can be three
// (R5) pair three encoded as 11 otherwise
// (R6) fault register layout, error flag writable
// (R7) error flag set on entering error
// (R8) writing zero clears error, re-evaluates conditions
// (R9) error state held while fault bits set
// (R10) auto-recovery clears error flag when clean
// (R11) power enable low clears error flag
// (R12) attach bit toggles on bypass overload
// (R13) fault bits raise alert, clear on read
// (R14) reset bit set at power-up, no alert
// (R15) alert independent of error flag
module fes_top
   import fes_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic RESET_N_I,
   input wire fes_req_t REG_REQ_I,
   input wire fes_cond_t FAULT_COND_I,
   input wire fes_emu_t EMU_I,
   input wire logic PORT_POWER_ENABLE_I,
   input wire logic AUTO_RECOVERY_I,
   input wire logic MAIN_SUPPLY_OK_I,
   input wire logic BYPASS_OVERLOAD_I,
   input wire logic ATTACH_DETECT_I,
   output logic [7:0] REG_RDATA_O,
   output logic REG_RVALID_O,
   output logic ALERT_N_O,
   output logic ERROR_STATE_O,
   output logic EMULATING_FLAG_O
);

   fes_st_t st_q;
   fes_st_t st_d;
   logic [`FES_NUM_FAULTS-1:0] cond;
   logic [`FES_NUM_FAULTS-1:0] faults;
   logic any_cond;
   logic any_fault;
   logic fault_rd;
   logic err_wr_zero;
   logic err_clr;

   // ------------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction

   // fault bits laid out as the status register
   function automatic logic [7:0] fault_reg(input logic e, input logic r,
                                            input logic [5:0] f);
      fault_reg = {e, f[5], r, f[4:0]};
   endfunction

   assign cond = FAULT_COND_I;
   assign any_cond = |cond;
   assign any_fault = |faults;
   assign fault_rd = REG_REQ_I.rd &&
                     hit(REG_REQ_I.addr, `FES_FAULT_STATUS_ADDR);
   assign err_wr_zero = REG_REQ_I.wr &&
                        hit(REG_REQ_I.addr, `FES_FAULT_STATUS_ADDR) &&
                        !REG_REQ_I.wdata[`FES_ERR_BIT];
   // fault bits drop with the error flag, unless still live
   assign err_clr = st_q.err && !st_d.err; // R13

   // ------------------------------------------------------------------
   // sticky fault bits
   // ------------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `FES_NUM_FAULTS; gi = gi + 1) begin : g_fault
         fes_fault_bit u_bit (
            .clk_i(CLOCK_I),
            .rst_n_i(RESET_N_I),
            .cond_i(cond[gi] && PORT_POWER_ENABLE_I), // R13
            .read_clr_i(fault_rd), // R13
            .err_clr_i(err_clr), // R13
            .flag_o(faults[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // next state of the whole block
   // ------------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.pwr_prev = PORT_POWER_ENABLE_I;
      // error flag: set wins over every clear
      if (PORT_POWER_ENABLE_I && any_cond) begin
         st_d.err = 1'b1; // R7
      end else if (!PORT_POWER_ENABLE_I) begin
         st_d.err = 1'b0; // R11
      end else if (err_wr_zero) begin
         st_d.err = 1'b0; // R8
      end else if (AUTO_RECOVERY_I) begin
         st_d.err = 1'b0; // R10
      end
      // latched faults keep the device in error after any clear except power enable low, which forces idle
      if (!PORT_POWER_ENABLE_I) begin
         st_d.state = FES_ST_IDLE;
      end else if (any_cond || st_d.err || any_fault) begin
         st_d.state = FES_ST_ERROR; // R9
      end else begin
         st_d.state = FES_ST_ACTIVE; // R8
      end
      // registered copy so the error output needs no decode after the flop
      st_d.in_error = (st_d.state == FES_ST_ERROR); // R9
      // reset bit: set once after power-up, dropped by read or toggle
      st_d.por_done = 1'b1;
      if (!st_q.por_done) begin
         st_d.reset_flag = 1'b1; // R14
      end else if (fault_rd || (PORT_POWER_ENABLE_I != st_q.pwr_prev)) begin
         st_d.reset_flag = 1'b0; // R14
      end
      // emulation reporting follows the engine with no software action
      st_d.emulating = (st_q.state == FES_ST_ACTIVE) && EMU_I.running; // R1
      if (!st_d.emulating) begin
         st_d.pair = `FES_PAIR_NONE; // R3
      end else if (EMU_I.legacy && EMU_I.pair == `FES_PAIR_THREE) begin
         st_d.pair = st_q.pair; // R4
      end else begin
         st_d.pair = EMU_I.pair; // R3 R5
      end
      if (st_d.emulating) begin
         st_d.profile = EMU_I.profile; // R2
      end
      // overload on the bypass path makes the attach bit cycle
      if (PORT_POWER_ENABLE_I && !MAIN_SUPPLY_OK_I && BYPASS_OVERLOAD_I) begin
         st_d.attach = !st_q.attach; // R12
      end else begin
         st_d.attach = ATTACH_DETECT_I;
      end
      // alert from fault bits only; reset bit and error flag excluded
      st_d.alert_n = !any_fault; // R13 R14 R15
      // read port, one cycle latency; unmapped offsets read zero
      st_d.rvalid = REG_REQ_I.rd;
      if (REG_REQ_I.rd) begin
         if (hit(REG_REQ_I.addr, `FES_FAULT_STATUS_ADDR)) begin
            st_d.rdata = fault_reg(st_q.err, st_q.reset_flag, faults); // R6
         end else if (hit(REG_REQ_I.addr, `FES_EMU_STATUS_ADDR)) begin
            st_d.rdata = {3'h0, st_q.attach, 1'b0, st_q.emulating, st_q.pair};
         end else if (hit(REG_REQ_I.addr, `FES_PROFILE_ADDR)) begin
            st_d.rdata = {4'h0, st_q.profile}; // R2
         end else begin
            st_d.rdata = `FES_REG_RESET;
         end
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         st_q <= '0; // R6
         st_q.state <= FES_ST_IDLE;
         st_q.alert_n <= 1'b1;
         st_q.profile <= `FES_PROFILE_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from flip-flops
   assign REG_RDATA_O = st_q.rdata;
   assign REG_RVALID_O = st_q.rvalid;
   assign ALERT_N_O = st_q.alert_n;
   assign ERROR_STATE_O = st_q.in_error;
   assign EMULATING_FLAG_O = st_q.emulating;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESET_N_I);

   sequence s_sw_clear;
      err_wr_zero && PORT_POWER_ENABLE_I && !any_cond;
   endsequence

   sequence s_clean_after;
      ##1 !st_q.err ##1 (!any_fault || $past(any_cond));
   endsequence

   a_emu_flag_set: assert property ( // R1
      (st_q.state == FES_ST_ACTIVE && EMU_I.running) |=> EMULATING_FLAG_O)
      else $error("emulating flag missing while active");

   a_emu_flag_clr: assert property ( // R1
      !(st_q.state == FES_ST_ACTIVE && EMU_I.running) |=> !EMULATING_FLAG_O)
      else $error("emulating flag set while not emulating");

   a_pair_none: assert property ( // R3
      !EMULATING_FLAG_O |-> st_q.pair == `FES_PAIR_NONE)
      else $error("pair index nonzero while idle");

   a_legacy_pair: assert property ( // R4
      (EMU_I.legacy && st_q.pair != `FES_PAIR_THREE) |=>
      st_q.pair != `FES_PAIR_THREE)
      else $error("legacy profile shows third pair");

   a_err_sets: assert property ( // R7
      (PORT_POWER_ENABLE_I && any_cond) |=>
      st_q.err && st_q.state == FES_ST_ERROR)
      else $error("error flag not set on fault");

   a_sw_clear: assert property ( // R8
      s_sw_clear |-> s_clean_after)
      else $error("software clear of error flag failed");

   a_error_hold: assert property ( // R9
      (PORT_POWER_ENABLE_I && any_fault) |=> ERROR_STATE_O)
      else $error("left error state with fault bit set");

   a_auto_clear: assert property ( // R10
      (AUTO_RECOVERY_I && PORT_POWER_ENABLE_I && !any_cond && st_q.err)
      |=> !st_q.err)
      else $error("auto recovery did not clear error flag");

   a_pwr_clear: assert property ( // R11
      !PORT_POWER_ENABLE_I |=> !st_q.err && !ERROR_STATE_O)
      else $error("error flag kept with power disabled");

   a_attach_toggle: assert property ( // R12
      (PORT_POWER_ENABLE_I && !MAIN_SUPPLY_OK_I && BYPASS_OVERLOAD_I) |=>
      st_q.attach != $past(st_q.attach))
      else $error("attach bit did not cycle on overload");

   a_alert_fault: assert property ( // R13
      any_fault |=> !ALERT_N_O)
      else $error("alert not asserted for fault bit");

   a_reset_bit: assert property ( // R14
      (st_q.por_done && PORT_POWER_ENABLE_I != st_q.pwr_prev) |=>
      !st_q.reset_flag && (ALERT_N_O == !$past(any_fault)))
      else $error("reset bit kept after power toggle");

endmodule

// ### core/fes_consts.svh
// register offsets, bit positions and codes of the fault/emulation status
`ifndef FES_CONSTS_SVH
`define FES_CONSTS_SVH

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define FES_EMU_STATUS_ADDR 8'h0f
`define FES_FAULT_STATUS_ADDR 8'h10
`define FES_PROFILE_ADDR 8'h12

// ------------------------------------------------------------------
// fault_status field positions
// ------------------------------------------------------------------
`define FES_ERR_BIT 7
`define FES_DISCH_BIT 6
`define FES_RESET_BIT 5
`define FES_NUM_FAULTS 6

// ------------------------------------------------------------------
// emulation_status field positions and pair codes
// ------------------------------------------------------------------
`define FES_ATTACH_BIT 4
`define FES_EMU_ACT_BIT 2
`define FES_PAIR_NONE 2'h0
`define FES_PAIR_THREE 2'h3

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define FES_REG_RESET 8'h00
`define FES_PROFILE_RESET 4'h0

`endif

// ### core/fes_pkg.sv
// types shared by the fault and emulation status logic
package fes_pkg;

   // ------------------------------------------------------------------
   // operating states
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      FES_ST_IDLE,
      FES_ST_ACTIVE,
      FES_ST_ERROR
   } fes_state_t;

   // live fault conditions, ordered as the low status bits plus discharge
   typedef struct packed {
      logic disch;
      logic undervolt;
      logic thermal_shutdown;
      logic overvoltage;
      logic back_voltage;
      logic overcurrent;
   } fes_cond_t;

   // report from the charger emulation engine
   typedef struct packed {
      logic running;
      logic legacy;
      logic [1:0] pair;
      logic [3:0] profile;
   } fes_emu_t;

   // register access from the management bus engine
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } fes_req_t;

   // state of one sticky fault bit
   typedef struct packed {
      logic flag;
   } fes_bit_st_t;

   // state of the top block
   typedef struct packed {
      fes_state_t state;
      logic in_error;
      logic err;
      logic reset_flag;
      logic por_done;
      logic pwr_prev;
      logic emulating;
      logic [1:0] pair;
      logic [3:0] profile;
      logic attach;
      logic alert_n;
      logic [7:0] rdata;
      logic rvalid;
   } fes_st_t;

endpackage

// ### core/fes_fault_bit.sv
// one sticky fault status bit with clear-on-read
`timescale 1ns/1ps
module fes_fault_bit
   import fes_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cond_i,
   input wire logic read_clr_i,
   input wire logic err_clr_i,
   output logic flag_o
);

   fes_bit_st_t st_q;
   fes_bit_st_t st_d;

   // ------------------------------------------------------------------
   // next value: a live condition always wins over any clear
   // ------------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      if (cond_i) begin
         st_d.flag = 1'b1;
      end else if (read_clr_i || err_clr_i) begin
         st_d.flag = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign flag_o = st_q.flag;

endmodule

// ### sim/fes_top_tb.sv
// self-checking bench for the fault and emulation status registers
`timescale 1ns/1ps
module fes_top_tb;
   import fes_pkg::*;
   // ------------------------------------------------------------------
   // stimulus and observation
   // ------------------------------------------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   fes_req_t req = '0;
   fes_cond_t cond = '0;
   fes_emu_t emu = '0;
   logic pwr = 1'b1;
   logic auto = 1'b0;
   logic supply_ok = 1'b1;
   logic overload = 1'b0;
   logic attach = 1'b0;
   logic [7:0] rdata;
   logic rvalid;
   logic alert_n;
   logic err_st;
   logic emu_flag;
   logic [7:0] d0;
   logic [7:0] d1;
   int miscompares = 0;
   int checks = 0;
   // 20 MHz clock
   always #25 clk = ~clk;
   fes_top i_fes_top (.CLOCK_I(clk), .RESET_N_I(rst_n), .REG_REQ_I(req),
      .FAULT_COND_I(cond), .EMU_I(emu), .PORT_POWER_ENABLE_I(pwr),
      .AUTO_RECOVERY_I(auto), .MAIN_SUPPLY_OK_I(supply_ok),
      .BYPASS_OVERLOAD_I(overload), .ATTACH_DETECT_I(attach),
      .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .ALERT_N_O(alert_n),
      .ERROR_STATE_O(err_st), .EMULATING_FLAG_O(emu_flag));
   // ------------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------------
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // read accepts an answer up to three edges after the request is taken; none ends the run
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      n = 0;
      d = 8'h00;
      @(posedge clk);
      req.rd <= 1'b1;
      req.addr <= a;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      while (rvalid !== 1'b1 && n < 4) begin
         cyc(1);
         n++;
      end
      if (n == 4) begin
         miscompares++;
         $display("CHECK FAILED read valid expected 1 seen 0");
         end_of_test();
      end else begin
         d = rdata;
      end
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [7:0] e, input logic [7:0] m);
      logic [7:0] d;
      rd(a, d);
      chk(nm, e, d & m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      req.wr <= 1'b1;
      req.addr <= a;
      req.wdata <= v;
      @(posedge clk);
      req.wr <= 1'b0;
      #1;
   endtask
   // one-cycle condition pulse, returns when the alert should be low
   task automatic flt(input int i);
      @(posedge clk);
      cond <= fes_cond_t'(6'h01 << i);
      @(posedge clk);
      cond <= '0;
      cyc(2);
   endtask
   // bounded wait for leaving the error state
   task automatic err_gone();
      int n;
      n = 0;
      while (err_st !== 1'b0 && n < 8) begin
         cyc(1);
         n++;
      end
      chk("error state", 8'h00, {7'h00, err_st});
      // a stuck error state ends the run at once
      if (err_st !== 1'b0) begin
         end_of_test();
      end
   endtask
   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      logic [7:0] map [6];
      map = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h40};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      // power-up: reset bit only, no alert, cleared by reading
      chk("alert", 8'h01, {7'h00, alert_n});
      rchk("fault first", 8'h10, 8'h20, 8'hff);
      rchk("fault again", 8'h10, 8'h00, 8'hff);
      rchk("emu status", 8'h0f, 8'h00, 8'hff);
      rchk("unmapped", 8'h33, 8'h00, 8'hff);
      wr(8'h10, 8'hff);
      rchk("ro bits", 8'h10, 8'h00, 8'hff);
      $display("test reset done");
      // every fault condition: latch, alert, error, write-zero clear
      for (int i = 0; i < 6; i++) begin
         flt(i);
         chk("alert low", 8'h00, {7'h00, alert_n});
         chk("error set", 8'h01, {7'h00, err_st});
         rchk("fault latch", 8'h10, 8'h80 | map[i], 8'hff);
         rchk("read clear", 8'h10, 8'h80, 8'hff);
         wr(8'h10, 8'h00);
         cyc(2);
         chk("cleared", 8'h00, {7'h00, err_st});
         rchk("after clear", 8'h10, 8'h00, 8'hff);
      end
      $display("test faults done");
      // live condition keeps the error state despite the clear
      @(posedge clk);
      cond <= fes_cond_t'(6'h20);
      cyc(3);
      wr(8'h10, 8'h00);
      cyc(2);
      chk("held", 8'h01, {7'h00, err_st});
      rchk("held bits", 8'h10, 8'hc0, 8'hff);
      @(posedge clk);
      cond <= '0;
      cyc(1);
      wr(8'h10, 8'h00);
      err_gone();
      rchk("released", 8'h10, 8'h00, 8'hff);
      $display("test hold done");
      // auto-recovery drops the flag, and with it the latched bits
      @(posedge clk);
      auto <= 1'b1;
      flt(0);
      cyc(2);
      rchk("auto flag", 8'h10, 8'h00, 8'hff);
      err_gone();
      @(posedge clk);
      auto <= 1'b0;
      $display("test auto done");
      // power enable low clears the error flag
      flt(0);
      @(posedge clk);
      pwr <= 1'b0;
      cyc(2);
      rchk("pwr off", 8'h10, 8'h00, 8'h80);
      @(posedge clk);
      pwr <= 1'b1;
      cyc(2);
      rchk("pwr on", 8'h10, 8'h00, 8'hff);
      err_gone();
      $display("test power done");
      // emulation flag, pair index and profile field
      for (int p = 0; p < 4; p++) begin
         @(posedge clk);
         emu <= '{1'b1, 1'b0, 2'(p), 4'h5};
         cyc(2);
         chk("emulating", 8'h01, {7'h00, emu_flag});
         rchk("pair", 8'h0f, 8'h04 | 8'(p), 8'hff);
      end
      rchk("profile", 8'h12, 8'h05, 8'h0f);
      @(posedge clk);
      emu <= '{1'b1, 1'b0, 2'h2, 4'h5};
      cyc(2);
      @(posedge clk);
      emu <= '{1'b1, 1'b1, 2'h3, 4'h9};
      cyc(2);
      rchk("legacy", 8'h0f, 8'h06, 8'h07);
      @(posedge clk);
      emu <= '0;
      cyc(2);
      chk("not emulating", 8'h00, {7'h00, emu_flag});
      $display("test emulation done");
      // attach bit follows the pin, toggles on bypass overload
      @(posedge clk);
      attach <= 1'b1;
      cyc(1);
      rchk("attach", 8'h0f, 8'h10, 8'h10);
      @(posedge clk);
      supply_ok <= 1'b0;
      overload <= 1'b1;
      req.rd <= 1'b1;
      req.addr <= 8'h0f;
      cyc(3);
      d0 = rdata;
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      d1 = rdata;
      chk("toggle", d0[4] ^ 1'b1, d1[4]);
      $display("test attach done");
      // mid-run reset sets the reset bit, a power toggle drops it
      @(posedge clk);
      supply_ok <= 1'b1;
      overload <= 1'b0;
      rst_n <= 1'b0;
      cyc(2);
      @(posedge clk);
      rst_n <= 1'b1;
      cyc(2);
      @(posedge clk);
      pwr <= 1'b0;
      @(posedge clk);
      pwr <= 1'b1;
      cyc(1);
      rchk("pwr toggle", 8'h10, 8'h00, 8'hff);
      $display("test toggle done");
      end_of_test();
   end
endmodule
